// [inc/cbbc_defines.svh]
// constants for the conditional branch / bit clear execution block
// assumes a 16-bit instruction word and an 8-bit data path
// ==========================================================
// Operation
// - upper byte E2 branches when carry set
// - upper byte E3 branches when carry clear
// - upper byte E6 branches when negative set
// - upper byte E7 branches when negative clear
// - upper byte E5 branches when overflow clear
// - taken target is incremented counter plus 2n
// - one cycle untaken, two cycles taken
// - phases decode, read, process, write; then wrap back to decode
// - access select zero uses access bank
// - access select one uses bank select register
// - extended set, a zero, f<=95 uses indexed
// - upper byte E1 branches when zero clear
`ifndef CBBC_DEFINES_SVH
`define CBBC_DEFINES_SVH

// ==========================================================
// opcodes
`define CBBC_OP_BR_CARRY_SET 8'hE2
`define CBBC_OP_BR_CARRY_CLR 8'hE3
`define CBBC_OP_BR_NEG_SET 8'hE6
`define CBBC_OP_BR_NEG_CLR 8'hE7
`define CBBC_OP_BR_OVF_CLR 8'hE5
`define CBBC_OP_BR_ZERO_CLR 8'hE1
`define CBBC_OP_BIT_CLEAR 4'h9

// ==========================================================
// field positions
`define CBBC_F_BIT_HI 11
`define CBBC_F_BIT_LO 9
`define CBBC_F_ACCESS 8
`define CBBC_INDEXED_MAX 8'h5F

// ==========================================================
// reset values and counts
`define CBBC_PC_RESET 21'h000000
`define CBBC_PC_STEP 21'h000002
`define CBBC_PHASES 4

`endif

// [inc/cbbc_pkg.sv]
// types for the conditional branch / bit clear execution block
// assumes the defines header is included by the users
package cbbc_pkg;

  typedef enum logic [1:0] {
    CBBC_Q1,
    CBBC_Q2,
    CBBC_Q3,
    CBBC_Q4
  } cbbc_phase_t;

  typedef enum logic [2:0] {
    CBBC_K_NONE,
    CBBC_K_BRANCH,
    CBBC_K_BIT_CLEAR
  } cbbc_kind_t;

endpackage

// [hw/cbbc_phase_gen.sv]
// four-phase generator dividing each instruction cycle
// assumes a synchronous active-low reset from the core
`timescale 1ns/10ps
module cbbc_phase_gen (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_N,
  // phase
  output cbbc_pkg::cbbc_phase_t phase,
  output logic cycle_end
);

  cbbc_pkg::cbbc_phase_t phase_q;
  cbbc_pkg::cbbc_phase_t phase_d;

  always_comb begin
    case (phase_q)
      cbbc_pkg::CBBC_Q1: phase_d = cbbc_pkg::CBBC_Q2;
      cbbc_pkg::CBBC_Q2: phase_d = cbbc_pkg::CBBC_Q3;
      cbbc_pkg::CBBC_Q3: phase_d = cbbc_pkg::CBBC_Q4;
      default: phase_d = cbbc_pkg::CBBC_Q1;
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      phase_q <= cbbc_pkg::CBBC_Q1;
    end else begin
      phase_q <= phase_d;
    end
  end

  assign phase = phase_q;
  assign cycle_end = (phase_q == cbbc_pkg::CBBC_Q4);

endmodule

// [hw/cbbc_exec.sv]
// execution sequencing for conditional short branches and bit clear
// assumes the instruction word is held stable for the whole cycle
// and that the core fetches at PC when INSTR_TAKE pulses
`include "cbbc_defines.svh"
`timescale 1ns/10ps
module cbbc_exec #(
  parameter int PC_W = 21
) (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_N,
  // instruction
  input wire logic [15:0] INSTR,
  input wire logic INSTR_VALID,
  output logic INSTR_TAKE,
  // status flags from the core
  input wire logic FLAG_CARRY,
  input wire logic FLAG_NEG,
  input wire logic FLAG_OVF,
  input wire logic FLAG_ZERO,
  input wire logic EXT_SET_EN,
  // bank selection
  input wire logic [5:0] BANK_SEL,
  input wire logic [7:0] INDEX_BASE,
  // program counter
  output logic [PC_W-1:0] PC,
  output logic PC_WRITE,
  output logic FLAGS_WE,
  // file register port
  output logic [13:0] FILE_ADDR,
  output logic FILE_RD,
  input wire logic [7:0] FILE_RDATA,
  output logic FILE_WR,
  output logic [7:0] FILE_WDATA,
  // phase view
  output logic [1:0] PHASE,
  output logic FLUSH
);

  // ==========================================================
  // functions
  function automatic logic [PC_W-1:0] branch_target(
    input logic [PC_W-1:0] pc_inc,
    input logic [7:0] n
  );
    logic [PC_W-1:0] off;
    off = {{(PC_W-9){n[7]}}, n, 1'b0};
    branch_target = pc_inc + off;
  endfunction

  // ==========================================================
  // phase generator
  cbbc_pkg::cbbc_phase_t phase;
  logic cycle_end;

  cbbc_phase_gen u_phase (
    .SYS_CLK(SYS_CLK),
    .RST_N(RST_N),
    .phase(phase),
    .cycle_end(cycle_end)
  );

  // ==========================================================
  // decode
  wire [7:0] op_hi = INSTR[15:8];
  wire [7:0] lit_n = INSTR[7:0];
  wire is_carry_set = (op_hi == `CBBC_OP_BR_CARRY_SET);
  wire is_carry_clr = (op_hi == `CBBC_OP_BR_CARRY_CLR);
  wire is_neg_set = (op_hi == `CBBC_OP_BR_NEG_SET);
  wire is_neg_clr = (op_hi == `CBBC_OP_BR_NEG_CLR);
  wire is_ovf_clr = (op_hi == `CBBC_OP_BR_OVF_CLR);
  wire is_zero_clr = (op_hi == `CBBC_OP_BR_ZERO_CLR);
  wire is_branch = is_carry_set | is_carry_clr | is_neg_set | is_neg_clr
    | is_ovf_clr | is_zero_clr;
  wire is_bclr = (INSTR[15:12] == `CBBC_OP_BIT_CLEAR);
  wire cond_true = (is_carry_set & FLAG_CARRY)
    | (is_carry_clr & ~FLAG_CARRY)
    | (is_neg_set & FLAG_NEG)
    | (is_neg_clr & ~FLAG_NEG)
    | (is_ovf_clr & ~FLAG_OVF)
    | (is_zero_clr & ~FLAG_ZERO);

  // ==========================================================
  // bit clear addressing
  wire [2:0] bit_sel = INSTR[`CBBC_F_BIT_HI:`CBBC_F_BIT_LO];
  wire acc_sel = INSTR[`CBBC_F_ACCESS];
  wire [7:0] f_addr = INSTR[7:0];
  wire use_indexed = ~acc_sel & EXT_SET_EN
    & (f_addr <= `CBBC_INDEXED_MAX);
  // access bank: low half in bank 0, upper half in the top bank
  wire [13:0] acc_addr = f_addr[7] ? {6'h3F, f_addr}
    : {6'h00, f_addr};
  wire [13:0] bank_addr = {BANK_SEL, f_addr};
  wire [13:0] idx_addr = {6'h00, INDEX_BASE} + {6'h00, f_addr};
  wire [13:0] sel_addr = use_indexed ? idx_addr
    : (acc_sel ? bank_addr : acc_addr);
  wire [7:0] clr_mask = ~(8'h01 << bit_sel);

  // ==========================================================
  // cycle state
  logic [PC_W-1:0] pc_q, pc_d;
  logic flush_q, flush_d;
  logic [7:0] n_q, n_d;
  logic taken_q, taken_d;
  logic bclr_q, bclr_d;
  logic [7:0] fdata_q, fdata_d;
  logic [13:0] faddr_q, faddr_d;

  wire in_q1 = (phase == cbbc_pkg::CBBC_Q1);
  wire in_q2 = (phase == cbbc_pkg::CBBC_Q2);
  wire in_q3 = (phase == cbbc_pkg::CBBC_Q3);
  wire in_q4 = (phase == cbbc_pkg::CBBC_Q4);
  wire active = INSTR_VALID & ~flush_q;
  wire [PC_W-1:0] pc_inc = pc_q + PC_W'(`CBBC_PC_STEP);

  // decode in Q1, latch literal in Q2, resolve in Q3, write in Q4
  always_comb begin
    n_d = n_q;
    taken_d = taken_q;
    bclr_d = bclr_q;
    fdata_d = fdata_q;
    faddr_d = faddr_q;
    if (in_q1) begin
      bclr_d = active & is_bclr;
      taken_d = 1'b0;
      faddr_d = sel_addr;
    end
    if (in_q2) begin
      n_d = lit_n;
      if (bclr_q) begin
        fdata_d = FILE_RDATA;
      end
    end
    if (in_q3) begin
      taken_d = active & is_branch & cond_true;
      if (bclr_q) begin
        fdata_d = fdata_q & clr_mask;
      end
    end
  end

  always_comb begin
    pc_d = pc_q;
    flush_d = flush_q;
    if (in_q4) begin
      if (flush_q) begin
        flush_d = 1'b0;
      end else if (taken_q) begin
        pc_d = branch_target(pc_inc, n_q);
        flush_d = 1'b1;
      end else if (INSTR_VALID) begin
        pc_d = pc_inc;
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      pc_q <= PC_W'(`CBBC_PC_RESET);
      flush_q <= 1'b0;
      n_q <= 8'h00;
      taken_q <= 1'b0;
      bclr_q <= 1'b0;
      fdata_q <= 8'h00;
      faddr_q <= 14'h0000;
    end else begin
      pc_q <= pc_d;
      flush_q <= flush_d;
      n_q <= n_d;
      taken_q <= taken_d;
      bclr_q <= bclr_d;
      fdata_q <= fdata_d;
      faddr_q <= faddr_d;
    end
  end

  // ==========================================================
  // outputs
  assign PC = pc_q;
  assign PC_WRITE = in_q4 & taken_q & ~flush_q;
  assign INSTR_TAKE = in_q4 & ~flush_q & INSTR_VALID;
  // neither branches nor bit clear ever touch the status flags
  assign FLAGS_WE = 1'b0;
  assign FILE_ADDR = faddr_q;
  assign FILE_RD = in_q2 & bclr_q;
  assign FILE_WR = in_q4 & bclr_q;
  assign FILE_WDATA = fdata_q;
  assign PHASE = phase;
  assign FLUSH = flush_q;

  // ==========================================================
  // checks
  // flags are sampled on the Q3 edge, so the decision shows on the Q4 edge
  a_taken_target: assert property (
    @(posedge SYS_CLK) disable iff (!RST_N)
    PC_WRITE |=> (PC == branch_target($past(pc_inc), $past(n_q))))
    else $error("branch target wrong");

  a_taken_two_cycles: assert property (
    @(posedge SYS_CLK) disable iff (!RST_N)
    PC_WRITE |=> FLUSH [*4] ##1 !FLUSH)
    else $error("taken branch not two cycles");

  a_untaken_step: assert property (
    @(posedge SYS_CLK) disable iff (!RST_N)
    (INSTR_TAKE && !PC_WRITE) |=> (PC == $past(pc_inc)))
    else $error("fall through wrong");

  a_untaken_no_flush: assert property (
    @(posedge SYS_CLK) disable iff (!RST_N)
    (INSTR_TAKE && !PC_WRITE) |=> !FLUSH)
    else $error("untaken branch lost a cycle");

  a_flush_quiet: assert property (
    @(posedge SYS_CLK) disable iff (!RST_N)
    FLUSH |-> !PC_WRITE && !FILE_WR && !INSTR_TAKE)
    else $error("operation during no-op cycle");

  a_phase_order: assert property (
    @(posedge SYS_CLK) disable iff (!RST_N)
    (PHASE == 2'h3) |=> (PHASE == 2'h0))
    else $error("phase did not wrap");

  a_reset_state: assert property (
    @(posedge SYS_CLK)
    !RST_N |=> (PHASE == 2'h0 && !FLUSH && PC == '0 && !FILE_WR))
    else $error("reset state wrong");

  a_carry_set: assert property (
    @(posedge SYS_CLK) disable iff (!RST_N)
    (in_q3 && active && is_carry_set && !FLAG_CARRY) |=> !PC_WRITE)
    else $error("carry branch taken wrongly");

  a_carry_set_take: assert property (
    @(posedge SYS_CLK) disable iff (!RST_N)
    (in_q3 && active && is_carry_set && FLAG_CARRY) |=> PC_WRITE)
    else $error("carry branch not taken");

  a_carry_clear: assert property (
    @(posedge SYS_CLK) disable iff (!RST_N)
    (in_q3 && active && is_carry_clr) |=> (PC_WRITE == !$past(FLAG_CARRY)))
    else $error("carry-clear branch wrong");

  a_neg_set: assert property (
    @(posedge SYS_CLK) disable iff (!RST_N)
    (in_q3 && active && is_neg_set) |=> (PC_WRITE == $past(FLAG_NEG)))
    else $error("negative branch wrong");

  a_neg_clear: assert property (
    @(posedge SYS_CLK) disable iff (!RST_N)
    (in_q3 && active && is_neg_clr) |=> (PC_WRITE == !$past(FLAG_NEG)))
    else $error("negative-clear branch wrong");

  a_ovf_clear: assert property (
    @(posedge SYS_CLK) disable iff (!RST_N)
    (in_q3 && active && is_ovf_clr) |=> (PC_WRITE == !$past(FLAG_OVF)))
    else $error("overflow-clear branch wrong");

  a_zero_clear: assert property (
    @(posedge SYS_CLK) disable iff (!RST_N)
    (in_q3 && active && is_zero_clr && !FLAG_ZERO) |=> PC_WRITE)
    else $error("zero-clear branch not taken");

  a_zero_set_hold: assert property (
    @(posedge SYS_CLK) disable iff (!RST_N)
    (in_q3 && active && is_zero_clr && FLAG_ZERO) |=> !PC_WRITE)
    else $error("zero-clear branch taken wrongly");

  a_bclr_write: assert property (
    @(posedge SYS_CLK) disable iff (!RST_N)
    FILE_RD |-> ##2 (FILE_WR &&
      FILE_WDATA == ($past(FILE_RDATA, 2) & $past(clr_mask, 1))))
    else $error("bit clear data wrong");

  a_bclr_one_rd: assert property (
    @(posedge SYS_CLK) disable iff (!RST_N)
    FILE_RD |=> !FILE_RD [*3])
    else $error("more than one read per cycle");

  a_branch_no_write: assert property (
    @(posedge SYS_CLK) disable iff (!RST_N)
    (in_q1 && active && is_branch) |=> ##2 !FILE_WR)
    else $error("branch wrote a file register");

  a_access_bank: assert property (
    @(posedge SYS_CLK) disable iff (!RST_N)
    (in_q1 && active && is_bclr && !acc_sel
      && (!EXT_SET_EN || f_addr > `CBBC_INDEXED_MAX)) |=>
      FILE_ADDR == {($past(f_addr[7]) ? 6'h3F : 6'h00), $past(f_addr)})
    else $error("access bank address wrong");

  a_bank_select: assert property (
    @(posedge SYS_CLK) disable iff (!RST_N)
    (in_q1 && active && is_bclr && acc_sel) |=>
      FILE_ADDR == {$past(BANK_SEL), $past(f_addr)})
    else $error("bank select not used");

  a_indexed_addr: assert property (
    @(posedge SYS_CLK) disable iff (!RST_N)
    (in_q1 && active && is_bclr && !acc_sel && EXT_SET_EN
      && f_addr <= `CBBC_INDEXED_MAX) |=>
      FILE_ADDR == {6'h00, $past(INDEX_BASE)} + {6'h00, $past(f_addr)})
    else $error("indexed address wrong");

  a_no_flags: assert property (
    @(posedge SYS_CLK) disable iff (!RST_N)
    !FLAGS_WE)
    else $error("flags written");

endmodule

// [test/cond_branch_bit_clear_exec_test.sv]
// self-checking bench for the branch / bit clear execution block
// assumes cbbc_exec with its defines header and package compiled first
`timescale 1ns/10ps
module cond_branch_bit_clear_exec_test;
  localparam int PC_W = 21;
  localparam int MAX_CYC = 4000;
  logic sys_clk, rst_n, instr_valid, instr_take;
  logic [15:0] instr;
  logic fc, fn, fo, fz, ext_en;
  logic [5:0] bank_sel;
  logic [7:0] index_base, file_rdata, file_wdata;
  logic [PC_W-1:0] pc, pc_m;
  logic pc_write, flags_we, file_rd, file_wr, flush;
  logic [13:0] file_addr;
  logic [1:0] phase;
  logic [45:0] got;
  logic [3:0] side;
  logic rd_seen = 1'b0;
  logic [45:0] exp_q[$], msk_q[$];
  logic [7:0] ops [6] = '{8'hE2, 8'hE3, 8'hE6, 8'hE7, 8'hE5, 8'hE1};
  int idx [6] = '{0, 0, 1, 1, 2, 3};
  logic want [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
  int errors, check_count, cyc;
  integer seed;

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  cbbc_exec #(.PC_W(PC_W)) dut_u (
    .SYS_CLK(sys_clk), .RST_N(rst_n),
    .INSTR(instr), .INSTR_VALID(instr_valid), .INSTR_TAKE(instr_take),
    .FLAG_CARRY(fc), .FLAG_NEG(fn), .FLAG_OVF(fo), .FLAG_ZERO(fz),
    .EXT_SET_EN(ext_en), .BANK_SEL(bank_sel), .INDEX_BASE(index_base),
    .PC(pc), .PC_WRITE(pc_write), .FLAGS_WE(flags_we),
    .FILE_ADDR(file_addr), .FILE_RD(file_rd), .FILE_RDATA(file_rdata),
    .FILE_WR(file_wr), .FILE_WDATA(file_wdata),
    .PHASE(phase), .FLUSH(flush)
  );

  // ==========================================================
  // driving
  task automatic step(input int k);
    repeat (k) @(posedge sys_clk);
    #2;
  endtask

  // fl is {zero, overflow, negative, carry}
  task automatic issue(input logic [15:0] w, input logic [3:0] fl,
                       input logic [45:0] e, input logic [45:0] m);
    instr = w;
    instr_valid = 1'b1;
    {fz, fo, fn, fc} = fl;
    exp_q.push_back(e);
    msk_q.push_back(m);
    step(4);
  endtask

  task automatic run_branch(input int k, input logic [7:0] n,
                            input logic [3:0] fl);
    logic tk;
    logic [PC_W-1:0] tgt;
    tk = (fl[idx[k]] == want[k]);
    tgt = pc_m + 21'h000002 + {{12{n[7]}}, n, 1'b0};
    pc_m = tk ? tgt : pc_m + 21'h000002;
    issue({ops[k], n}, fl, {pc_m, tk, 2'b00, 22'h000000},
          {{PC_W{1'b1}}, 3'b111, 22'h000000});
    // garbage during the dead cycle must not retire
    if (tk) begin
      instr = 16'($random(seed));
      check_count++;
      if (flush !== 1'b1) begin
        errors++;
        $display("[ERR] t=%0t flush=%h exp=%h", $time, flush, 1'b1);
      end
      step(4);
    end
  endtask

  task automatic run_clear(input logic [2:0] b, input logic a,
                           input logic [7:0] f, input logic x,
                           input logic [7:0] rd);
    logic [13:0] ad;
    logic [7:0] wd;
    ext_en = x;
    file_rdata = rd;
    bank_sel = 6'($random(seed));
    index_base = 8'($random(seed));
    if (a)
      ad = {bank_sel, f};
    else if (x && f <= 8'h5F)
      ad = 14'(index_base) + 14'(f);
    else
      ad = f[7] ? {6'h3F, f} : {6'h00, f};
    wd = rd & ~(8'h01 << b);
    pc_m = pc_m + 21'h000002;
    issue({4'h9, b, a, f}, 4'($random(seed)), {pc_m, 3'b010, ad, wd}, '1);
  endtask

  // ==========================================================
  // watching: one note popped per retired instruction
  always @(posedge sys_clk) begin
    if (file_rd === 1'b1)
      rd_seen = 1'b1;
    if (rst_n === 1'b1 && instr_take === 1'b1) begin
      got[24:0] = {pc_write, file_wr, flags_we, file_addr, file_wdata};
      side = {phase, flush, rd_seen};
      rd_seen = 1'b0;
      #1;
      got[45:25] = pc;
      check_count++;
      if (exp_q.size() == 0) begin
        errors++;
        $display("[ERR] t=%0t unexpected retire got=%h exp=%h",
                 $time, got, 46'h0);
      end else if ((got & msk_q[0]) !== (exp_q[0] & msk_q[0])) begin
        errors++;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got & msk_q[0],
                 exp_q[0] & msk_q[0]);
      end
      // retire lands in Q4, a read strobe only for a bit clear
      check_count++;
      if (exp_q.size() != 0
          && side !== {2'h3, 1'b0, exp_q[0][23]}) begin
        errors++;
        $display("[ERR] t=%0t side=%h exp=%h", $time, side,
                 {2'h3, 1'b0, exp_q[0][23]});
      end
      if (exp_q.size() != 0) begin
        void'(exp_q.pop_front());
        void'(msk_q.pop_front());
      end
    end
  end

  // ==========================================================
  // hang guard and verdict
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == MAX_CYC) begin
      errors++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    seed = 32'h0d771ac2;
    rst_n = 1'b0;
    instr = 16'h0000;
    instr_valid = 1'b0;
    {fz, fo, fn, fc, ext_en} = 5'h00;
    bank_sel = 6'h00;
    index_base = 8'h00;
    file_rdata = 8'h00;
    pc_m = '0;
    step(2);
    rst_n = 1'b1;
    for (int k = 0; k < 6; k++) begin
      run_branch(k, 8'h7F, 4'h0);
      run_branch(k, 8'h80, 4'hF);
      run_branch(k, 8'h80, 4'h0);
      run_branch(k, 8'($random(seed)), 4'($random(seed)));
    end
    $display("branch test done");
    run_clear(3'd7, 1'b0, 8'h5F, 1'b1, 8'hC7);
    run_clear(3'd0, 1'b0, 8'h60, 1'b1, 8'hFF);
    run_clear(3'd4, 1'b0, 8'h80, 1'b0, 8'hFF);
    run_clear(3'd2, 1'b1, 8'h10, 1'b1, 8'hFF);
    for (int i = 0; i < 40; i++)
      run_clear(3'($random(seed)), 1'($random(seed)), 8'($random(seed)),
                1'($random(seed)), 8'($random(seed)));
    $display("bit clear test done");
    // drop valid so the last word is not executed a second time
    instr_valid = 1'b0;
    step(4);
    if (exp_q.size() != 0) begin
      errors++;
      $display("[ERR] t=%0t pending=%h exp=%h", $time, exp_q.size(), 0);
    end
    tally_and_finish();
  end
endmodule
